// >>> design/nhsrw_pkg.sv
// package: constants and carrier structs for the head select / nrzi read-write block
package nhsrw_pkg;
  // clock rate and read strobe timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int STROBE_NS = 300;
  // nominal width rounds to whole cycles (300/40 -> 8)
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
  // track address layout
  localparam int TRK_W = 5;
  localparam int LOW_LSB = 0;
  localparam int LOW_W = 3;
  localparam int GRP_LSB = 3;
  localparam int GRP_W = 2;
  localparam int HEADS = 32;
  localparam logic [7:0] TAP_RST = 8'h00;
  localparam logic [3:0] GRP_RST = 4'h0;
  localparam logic [TRK_W-1:0] TRK_RST = 5'h00;

  // head selection lines, one-hot each
  typedef struct packed {
    logic [3:0] group_en;
    logic [7:0] tap_en;
  } nhsrw_sel_t;

  // writer transistor pair drive
  typedef struct packed {
    logic drive_a;
    logic drive_b;
  } nhsrw_wdrv_t;

  // read detector outputs, negative true
  typedef struct packed {
    logic strobe_n;
    logic polarity_n;
  } nhsrw_rd_t;
endpackage : nhsrw_pkg

// >>> design/nhsrw_sync.sv
// two-flop synchroniser for asynchronous level inputs
module nhsrw_sync #(
  parameter int W = 1
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } nhsrw_sync_st_t;

  nhsrw_sync_st_t st_q;
  nhsrw_sync_st_t st_d;

  // first stage feeds only the second stage
  always_comb begin
    st_d = st_q;
    if (ce_in) begin
      st_d.meta = async_in;
      st_d.stable = st_q.meta;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;
endmodule : nhsrw_sync

// >>> design/nhsrw_core.sv
// head select, write lockout, nrzi write flip-flop and read peak strobe logic
// Function
// - controller picks one of 32 heads by 5-bit address; exactly that head activates
// - upper two bits pick one of four groups, lower three one of eight taps
// - active tap and active group together form one path for read and write
// - nrzi recording: one reverses head current, zero leaves it unchanged
// - write data sampled on rising edge of bit-rate timing, oscillator divided by three
// - write flip-flop toggles on each sampled one, holds on zero
// - head current direction follows write flip-flop, one transistor on, other off, while write gate is on above the protected range; both off otherwise
// - each read peak gives negative-true strobe of 300 ns (8 cycles, 320 ns here), leading edge at peak
// - negative-true polarity pulse per positive head pulse, lasting as long as the head pulse
// - address at or below protect switches inhibits writer and raises lockout flag
module nhsrw_core (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic [4:0] track_addr_in,
  input wire logic [4:0] protect_limit_switches_in,
  input wire logic write_gate_in,
  input wire logic serial_write_data_in,
  input wire logic osc_in,
  input wire logic peak_in,
  input wire logic positive_pulse_in,
  output logic [3:0] group_en_out,
  output logic [7:0] tap_en_out,
  output logic write_drive_a_out,
  output logic write_drive_b_out,
  output logic write_protect_flag_out,
  output logic read_strobe_n_out,
  output logic read_polarity_n_out
);
  typedef enum logic [1:0] {
    DIV_0 = 2'b00,
    DIV_1 = 2'b01,
    DIV_2 = 2'b11
  } nhsrw_div_t;

  typedef struct packed {
    nhsrw_pkg::nhsrw_sel_t sel;
    nhsrw_pkg::nhsrw_wdrv_t wdrv;
    nhsrw_pkg::nhsrw_rd_t rd;
    nhsrw_div_t div;
    logic write_ff;
    logic lockout;
    logic peak_prev;
    logic [3:0] strobe_cnt;
  } nhsrw_st_t;

  nhsrw_st_t st_q;
  nhsrw_st_t st_d;
  logic [4:0] trk_s;
  logic [4:0] lim_s;
  logic gate_s;
  logic wdata_s;
  logic osc_s;
  logic peak_s;
  logic pos_s;
  logic osc_prev_q;
  logic bit_tick;
  logic write_ok;
  logic [1:0] rise_seen_q;

  // every controller and head input arrives asynchronously
  nhsrw_sync #(.W(15)) u_sync (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .async_in({track_addr_in, protect_limit_switches_in, write_gate_in,
      serial_write_data_in, osc_in, peak_in, positive_pulse_in}),
    .sync_out({trk_s, lim_s, gate_s, wdata_s, osc_s, peak_s, pos_s})
  );

  // one-hot decode used for both address fields
  function automatic logic [7:0] onehot8(input logic [2:0] idx);
    onehot8 = 8'h01 << idx;
  endfunction : onehot8

  // oscillator edge detect on the synchronised copy
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      osc_prev_q <= 1'b0;
    end else if (ce_in) begin
      osc_prev_q <= osc_s;
    end
  end

  // bit-rate rising edge: divide-by-three counter wraps to its first state
  assign bit_tick = osc_s && !osc_prev_q && (st_q.div == DIV_2);
  // writer is enabled only above the protected range
  assign write_ok = gate_s && (trk_s > lim_s);

  // assertion helper: oscillator rises counted modulo three, kept apart from the divider
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rise_seen_q <= 2'h0;
    end else if (ce_in && osc_s && !osc_prev_q) begin
      rise_seen_q <= (rise_seen_q == 2'h2) ? 2'h0 : rise_seen_q + 2'h1;
    end
  end

  always_comb begin
    st_d = st_q;
    if (ce_in) begin
      // two-part decode; one group and one tap select exactly one head
      st_d.sel.group_en = 4'(onehot8({1'b0, trk_s[nhsrw_pkg::GRP_LSB +: nhsrw_pkg::GRP_W]}));
      st_d.sel.tap_en = onehot8(trk_s[2:0]);
      st_d.lockout = (trk_s <= lim_s);
      // divider advances on each oscillator rising edge
      if (osc_s && !osc_prev_q) begin
        case (st_q.div)
          DIV_0: st_d.div = DIV_1;
          DIV_1: st_d.div = DIV_2;
          DIV_2: st_d.div = DIV_0;
          default: st_d.div = DIV_0;
        endcase
      end
      // nrzi: a sampled one complements the write flip-flop
      if (bit_tick && wdata_s) begin
        st_d.write_ff = !st_q.write_ff;
      end
      // complementary writer pair; both off when gated or locked out
      st_d.wdrv.drive_a = write_ok && st_q.write_ff;
      st_d.wdrv.drive_b = write_ok && !st_q.write_ff;
      // peak rising edge fires a fixed-width strobe; retrigger restarts it
      st_d.peak_prev = peak_s;
      if (peak_s && !st_q.peak_prev) begin
        st_d.strobe_cnt = nhsrw_pkg::STROBE_CNT;
      end else if (st_q.strobe_cnt != 4'h0) begin
        st_d.strobe_cnt = st_q.strobe_cnt - 4'h1;
      end
      st_d.rd.strobe_n = !(st_d.strobe_cnt != 4'h0);
      st_d.rd.polarity_n = !pos_s;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_q <= '{sel: '{group_en: nhsrw_pkg::GRP_RST, tap_en: nhsrw_pkg::TAP_RST},
        wdrv: '{drive_a: 1'b0, drive_b: 1'b0},
        rd: '{strobe_n: 1'b1, polarity_n: 1'b1},
        div: DIV_0, write_ff: 1'b0, lockout: 1'b1, peak_prev: 1'b0,
        strobe_cnt: 4'h0};
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from state flip-flops
  assign group_en_out = st_q.sel.group_en;
  assign tap_en_out = st_q.sel.tap_en;
  assign write_drive_a_out = st_q.wdrv.drive_a;
  assign write_drive_b_out = st_q.wdrv.drive_b;
  assign write_protect_flag_out = st_q.lockout;
  assign read_strobe_n_out = st_q.rd.strobe_n;
  assign read_polarity_n_out = st_q.rd.polarity_n;

  // reset clears all lines; exactly one group and one tap line active from the first enabled clock after reset
  AST_ONEHOT_SEL: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $past(ce_in) && !$past(reset_in) |-> $onehot(group_en_out) && $onehot(tap_en_out))
    else $error("head select not one-hot");

  AST_GROUP_MATCH: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ce_in |=> group_en_out == (4'h1 << $past(trk_s[4:3])))
    else $error("group enable does not follow upper address bits");

  AST_TAP_MATCH: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ce_in |=> tap_en_out == (8'h01 << $past(trk_s[2:0])))
    else $error("tap enable does not follow lower address bits");

  AST_TOGGLE_ONE: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ce_in && bit_tick && wdata_s |=> st_q.write_ff != $past(st_q.write_ff))
    else $error("write flip-flop missed a one");

  AST_HOLD_ZERO: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !(bit_tick && wdata_s) |=> $stable(st_q.write_ff))
    else $error("write flip-flop changed without a sampled one");

  AST_TICK_RATE: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ce_in |-> bit_tick == (osc_s && !osc_prev_q && rise_seen_q == 2'h2))
    else $error("bit tick not on every third oscillator rise");

  AST_DRIVE_EXCL: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !(write_drive_a_out && write_drive_b_out))
    else $error("both writer transistors on");

  AST_LOCKOUT: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ce_in && $past(ce_in) && (trk_s <= lim_s) && $stable(trk_s) && $stable(lim_s)
    |=> write_protect_flag_out && !write_drive_a_out && !write_drive_b_out)
    else $error("writer active on protected track");

  AST_STROBE_WIDTH: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ce_in && peak_s && !st_q.peak_prev ##1 ce_in [*7] |-> !read_strobe_n_out)
    else $error("read strobe shorter than nominal");

  AST_POLARITY: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ce_in |=> read_polarity_n_out == !$past(pos_s))
    else $error("polarity pulse does not track head pulse");

  COV_WRITE_ONE: cover property (@(posedge core_clk_in) disable iff (reset_in)
    bit_tick && wdata_s && write_ok);
  COV_LOCKED: cover property (@(posedge core_clk_in) disable iff (reset_in)
    gate_s && write_protect_flag_out);
  COV_STROBE: cover property (@(posedge core_clk_in) disable iff (reset_in)
    $fell(read_strobe_n_out));
  COV_TOP_HEAD: cover property (@(posedge core_clk_in) disable iff (reset_in)
    group_en_out == 4'h8 && tap_en_out == 8'h80);
endmodule : nhsrw_core

// >>> tb/nhsrw_ctrl_model.sv
// controller-side model: recovered oscillator source and read polarity checker
module nhsrw_ctrl_model (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic read_strobe_n_in,
  input wire logic read_polarity_n_in,
  output logic osc_out,
  output logic [1:0] osc_phase_out,
  output int pol_err_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_q;
  logic last_pol_q;
  logic have_q;
  // oscillator of 8 core cycles, free running like a timing track; phase counts rises mod 3
  always @(negedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_q <= 2'h0;
      osc_out <= 1'b0;
      osc_phase_out <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        osc_out <= ~osc_out;
        if (!osc_out) osc_phase_out <= (osc_phase_out == 2'h2) ? 2'h0 : osc_phase_out + 2'h1;
      end
    end
  end
  // two peaks of one polarity in a row mean a bad recording
  always @(negedge read_strobe_n_in or posedge reset_in) begin
    if (reset_in) begin
      have_q <= 1'b0;
      pol_err_out <= 0;
    end else begin
      if (have_q && last_pol_q == read_polarity_n_in) pol_err_out <= pol_err_out + 1;
      have_q <= 1'b1;
      last_pol_q <= read_polarity_n_in;
    end
  end
endmodule : nhsrw_ctrl_model

// >>> tb/nhsrw_core_bench.sv
// testbench: head select, lockout, nrzi write and read strobe checks
module nhsrw_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed { logic [2:0] kind; logic [11:0] val; } nhsrw_note_t;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, gate = 1'b0, wdat = 1'b0, peak = 1'b0, pos = 1'b0;
  logic [4:0] addr = 5'h00, lim = 5'h00;
  logic [3:0] grp;
  logic [7:0] tap;
  logic da, db, flag, stb_n, pol_n, osc;
  logic [1:0] ph;
  logic [31:0] rs = 32'h00002B1B;
  int perr, fails = 0, tests_run = 0, wid = 0, lastw = 0;
  nhsrw_note_t notes[$];
  event look;
  always #20 clk = ~clk;
  nhsrw_core dut (.core_clk_in(clk), .reset_in(rst), .ce_in(ce), .track_addr_in(addr),
    .protect_limit_switches_in(lim), .write_gate_in(gate), .serial_write_data_in(wdat),
    .osc_in(osc), .peak_in(peak), .positive_pulse_in(pos), .group_en_out(grp),
    .tap_en_out(tap), .write_drive_a_out(da), .write_drive_b_out(db),
    .write_protect_flag_out(flag), .read_strobe_n_out(stb_n), .read_polarity_n_out(pol_n));
  nhsrw_ctrl_model ctl (.core_clk_in(clk), .reset_in(rst), .read_strobe_n_in(stb_n),
    .read_polarity_n_in(pol_n), .osc_out(osc), .osc_phase_out(ph), .pol_err_out(perr));
  function automatic logic [31:0] nxt();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : nxt
  // strobe width in cycles, latched when the strobe ends; sampled away from the launching edge
  always @(negedge clk) begin
    if (!stb_n) wid <= wid + 1;
    else if (wid != 0) begin
      lastw <= wid;
      wid <= 0;
    end
  end
  task automatic note(input logic [2:0] k, input logic [11:0] v);
    notes.push_back({k, v});
    ->look;
  endtask : note
  task automatic report(input logic [11:0] e, input logic [11:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask : report
  task automatic cmp_sel(input logic [11:0] e);
    report(e, {grp, tap});
  endtask : cmp_sel
  task automatic cmp_drv(input logic [1:0] e);
    report({10'h000, e}, {10'h000, da, db});
  endtask : cmp_drv
  task automatic cmp_lvl(input logic e, input logic g);
    report({11'h000, e}, {11'h000, g});
  endtask : cmp_lvl
  task automatic cmp_cnt(input logic [11:0] e, input logic [11:0] g);
    report(e, g);
  endtask : cmp_cnt
  // monitor: every due note is compared against the output of its kind
  initial forever begin
    nhsrw_note_t n;
    @(look);
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n.kind)
        3'h0: cmp_sel(n.val);
        3'h1: cmp_drv(n.val[1:0]);
        3'h2: cmp_lvl(n.val[0], flag);
        3'h3: cmp_lvl(n.val[0], pol_n);
        3'h4: cmp_cnt(n.val, 12'(lastw));
        default: cmp_cnt(n.val, 12'(perr));
      endcase
    end
  end
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // a gap above zero sends a second peak that must restart the strobe
  task automatic pk(input logic p, input int gap);
    pos = p;
    @(negedge clk);
    peak = 1'b1;
    @(negedge clk);
    peak = 1'b0;
    if (gap > 0) begin
      repeat (gap) @(negedge clk);
      peak = 1'b1;
      @(negedge clk);
      peak = 1'b0;
    end
    repeat (4) @(negedge clk);
    note(3'h3, {11'h000, ~p});
    repeat (14) @(negedge clk);
    pos = 1'b0;
    note(3'h4, gap > 0 ? 12'h00C : 12'h008);
    repeat (4) @(negedge clk);
    note(3'h3, 12'h001);
  endtask : pk
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    stop_test();
  end
  initial begin
    logic e, b;
    logic [31:0] rnd;
    repeat (5) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    // every head, each with a random lockout limit
    for (int i = 0; i < 32; i++) begin
      addr = 5'(i);
      lim = 5'(nxt());
      repeat (4) @(negedge clk);
      note(3'h0, {4'h1 << addr[4:3], 8'h01 << addr[2:0]});
      note(3'h2, {11'h000, addr <= lim});
    end
    // nrzi write with two locked bits and a gate-off bit; data held zero so far keeps the ff at 0
    addr = 5'h1F;
    e = 1'b0;
    for (int i = 0; i < 16; i++) begin
      wait (ph == 2'h1);
      @(negedge clk);
      rnd = nxt();
      b = rnd[0] | (i == 8);
      wdat = b;
      e ^= b;
      lim = (i == 8 || i == 9) ? 5'h1F : 5'h00;
      gate = i != 12;
      // look one rise after the tick, before a later tick could sample this bit again
      wait (ph == 2'h0);
      wait (ph == 2'h1);
      @(negedge clk);
      note(3'h2, {11'h000, lim == 5'h1F});
      note(3'h1, (lim == 5'h1F || !gate) ? 12'h000 : {10'h000, e, ~e});
    end
    // reads: alternating peaks, one restarted strobe, then a repeated polarity
    gate = 1'b0;
    pk(1'b1, 0);
    pk(1'b0, 3);
    pk(1'b1, 0);
    pk(1'b1, 0);
    note(3'h5, 12'h001);
    // enable low freezes the head lines; done last since the divider misses rises meanwhile
    ce = 1'b0;
    addr = 5'h0A;
    repeat (6) @(negedge clk);
    note(3'h0, {4'h8, 8'h80});
    ce = 1'b1;
    repeat (4) @(negedge clk);
    note(3'h0, {4'h1 << addr[4:3], 8'h01 << addr[2:0]});
    repeat (2) @(negedge clk);
    stop_test();
  end
endmodule : nhsrw_core_bench
